// ===== verilog/spa_pkg.sv
package spa_pkg;
    // Password slot indices in the password system area
    localparam logic [1:0] SLOT_ONE = 2'h1;
    localparam logic [1:0] SLOT_TWO = 2'h2;
    localparam logic [1:0] SLOT_THREE = 2'h3;
    localparam logic [31:0] PASSWORD_RESET = 32'h0000_0000;
    localparam logic [7:0] GUARD_RESET = 8'h00;
    // Guard byte field positions
    localparam int GUARD_LOCK_BIT = 0;
    localparam int GUARD_PROT_LSB = 1;
    localparam int GUARD_LINK_LSB = 3;
    localparam logic [7:0] GUARD_LOCK_MASK = 8'h1F;
    // Protection codes
    localparam logic [1:0] PROT_WRITE_PWD = 2'h0;
    localparam logic [1:0] PROT_OPEN = 2'h1;
    localparam logic [1:0] PROT_ALL_PWD = 2'h2;
    localparam logic [1:0] PROT_READ_PWD = 2'h3;
    // Contactless command answers
    localparam logic [1:0] ANS_OK = 2'h0;
    localparam logic [1:0] ANS_ERR_LOCKED = 2'h1;
    localparam logic [1:0] ANS_ERR_DENIED = 2'h2;
    localparam logic [1:0] ANS_ERR_MISMATCH = 2'h3;
    typedef enum logic [1:0] {
        SPA_CMD_WRITE_PWD,
        SPA_CMD_LOCK,
        SPA_CMD_PRESENT
    } spa_cmd_t;
endpackage

// ===== verilog/spa_sector_guard.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Password-write command stores one 32-bit value into the selected slot.
// - A newly stored password is active at once, no further command.
// - Password-write accepted only after that slot's correct password was presented.
// - All three slots start at all-zero and active.
// - Lock command takes link and protection bits 4 down to 1 from the data and clears bits 7 down to 5.
// - Lock command forces bit 0 to one; protection applies immediately.
// - A locked sector's settings cannot change from the contactless side.
// - Locking an already locked sector gives an error, guard byte unchanged.
// - Matching presentation grants rights to linked sectors and to the slot.
// - Granted rights persist until power off or the next presentation.
// - A mismatching presentation revokes all granted rights.
// - Wired side may always read the guard bytes.
// - Wired guard writes need the wired password presented first.
// - A wired guard write resets that sector's contactless access condition.
// - Access follows the fixed lock and protection table.
// - Link bits 00 none, 01 slot one, 10 slot two, 11 slot three.
// - Every guard byte starts at zero: unlocked, unprotected.
module spa_sector_guard
    import spa_pkg::*;
#(
    parameter int SECTORS = 64,
    parameter int SECW = 6
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Contactless command port
    input wire logic rf_cmd_valid_i,
    input wire spa_cmd_t rf_cmd_i,
    input wire logic [1:0] rf_slot_i,
    input wire logic [SECW-1:0] rf_sector_i,
    input wire logic [31:0] rf_data_i,
    output logic rf_done_o,
    output logic [1:0] rf_answer_o,
    // Access query for the memory array
    input wire logic [SECW-1:0] query_sector_i,
    output logic query_read_ok_o,
    output logic query_write_ok_o,
    // Wired side guard byte access
    input wire logic chip_enable_select_bit_i,
    input wire logic wired_pwd_ok_i,
    input wire logic wired_rd_i,
    input wire logic wired_wr_i,
    input wire logic [SECW-1:0] wired_sector_i,
    input wire logic [7:0] wired_wdata_i,
    output logic [7:0] wired_rdata_o,
    output logic wired_ack_o,
    output logic wired_err_o
);
    logic [31:0] password_slot_one;
    logic [31:0] password_slot_two;
    logic [31:0] password_slot_three;
    logic [7:0] sector_guard_byte [SECTORS];
    logic [3:0] granted; // Bit n set: slot n presented correctly, bit 0 unused
    logic [31:0] slot_value;
    logic pwd_match;
    logic rf_go;
    logic wired_go;
    logic [7:0] cur_guard;
    logic [7:0] next_guard;

    // Stored value of the addressed slot; slot zero never matches
    always_comb begin
        unique case (rf_slot_i)
            SLOT_ONE: slot_value = password_slot_one;
            SLOT_TWO: slot_value = password_slot_two;
            SLOT_THREE: slot_value = password_slot_three;
            default: slot_value = PASSWORD_RESET;
        endcase
    end
    assign pwd_match = (rf_slot_i != 2'h0) && (rf_data_i == slot_value);
    assign rf_go = rf_cmd_valid_i;
    assign wired_go = chip_enable_select_bit_i;
    assign cur_guard = sector_guard_byte[rf_sector_i];
    assign next_guard = (rf_data_i[7:0] & GUARD_LOCK_MASK) | 8'h01;

    // Password storage, only reachable by the write command
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            password_slot_one <= PASSWORD_RESET;
            password_slot_two <= PASSWORD_RESET;
            password_slot_three <= PASSWORD_RESET;
        end else if (rf_go && rf_cmd_i == SPA_CMD_WRITE_PWD && granted[rf_slot_i]) begin
            unique case (rf_slot_i)
                SLOT_ONE: password_slot_one <= rf_data_i;
                SLOT_TWO: password_slot_two <= rf_data_i;
                SLOT_THREE: password_slot_three <= rf_data_i;
                default: ;
            endcase
        end
    end

    // Granted rights; a new presentation replaces the old set entirely
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            granted <= 4'h0;
        end else if (rf_go && rf_cmd_i == SPA_CMD_PRESENT) begin
            if (pwd_match) begin
                granted <= 4'h1 << rf_slot_i;
            end else begin
                granted <= 4'h0;
            end
        end
    end

    // Guard bytes: contactless lock and wired write share one write port per cycle,
    // the wired write wins since it also re-initialises the access condition
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < SECTORS; i++) begin
                sector_guard_byte[i] <= GUARD_RESET;
            end
        end else if (wired_go && wired_wr_i && wired_pwd_ok_i) begin
            sector_guard_byte[wired_sector_i] <= wired_wdata_i;
        end else if (rf_go && rf_cmd_i == SPA_CMD_LOCK && !cur_guard[GUARD_LOCK_BIT]) begin
            sector_guard_byte[rf_sector_i] <= next_guard;
        end
    end

    // Command answers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rf_done_o <= 1'b0;
            rf_answer_o <= ANS_OK;
        end else begin
            rf_done_o <= rf_go;
            rf_answer_o <= ANS_OK;
            if (rf_go) begin
                unique case (rf_cmd_i)
                    SPA_CMD_LOCK: begin
                        if (cur_guard[GUARD_LOCK_BIT]) rf_answer_o <= ANS_ERR_LOCKED;
                    end
                    SPA_CMD_WRITE_PWD: begin
                        if (!granted[rf_slot_i]) rf_answer_o <= ANS_ERR_DENIED;
                    end
                    SPA_CMD_PRESENT: begin
                        if (!pwd_match) rf_answer_o <= ANS_ERR_MISMATCH;
                    end
                    default: rf_answer_o <= ANS_ERR_DENIED;
                endcase
            end
        end
    end

    // Access table for the queried sector
    logic [7:0] q_guard;
    logic q_pwd;
    logic [1:0] q_prot;
    assign q_guard = sector_guard_byte[query_sector_i];
    assign q_prot = q_guard[GUARD_PROT_LSB +: 2];
    // Link 00 names no slot and granted bit 0 is never set, so no password opens it
    assign q_pwd = granted[q_guard[GUARD_LINK_LSB +: 2]];
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            query_read_ok_o <= 1'b1;
            query_write_ok_o <= 1'b1;
        end else if (!q_guard[GUARD_LOCK_BIT]) begin
            query_read_ok_o <= 1'b1;
            query_write_ok_o <= 1'b1;
        end else begin
            unique case (q_prot)
                PROT_WRITE_PWD: begin
                    query_read_ok_o <= 1'b1;
                    query_write_ok_o <= q_pwd;
                end
                PROT_OPEN: begin
                    query_read_ok_o <= 1'b1;
                    query_write_ok_o <= 1'b1;
                end
                PROT_ALL_PWD: begin
                    query_read_ok_o <= q_pwd;
                    query_write_ok_o <= q_pwd;
                end
                PROT_READ_PWD: begin
                    query_read_ok_o <= q_pwd;
                    query_write_ok_o <= 1'b0;
                end
            endcase
        end
    end

    // Wired side answers; reads never depend on password state
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wired_rdata_o <= GUARD_RESET;
            wired_ack_o <= 1'b0;
            wired_err_o <= 1'b0;
        end else begin
            wired_ack_o <= wired_go && (wired_rd_i || wired_wr_i);
            wired_err_o <= wired_go && wired_wr_i && !wired_pwd_ok_i;
            if (wired_go && wired_rd_i) begin
                wired_rdata_o <= sector_guard_byte[wired_sector_i];
            end
        end
    end

    // Checks
    // Sector and guard byte of the previous cycle, so a refused lock can be compared
    logic [SECW-1:0] prev_rf_sector;
    logic [7:0] prev_cur_guard;
    always_ff @(posedge clk_i) begin
        prev_rf_sector <= rf_sector_i;
        prev_cur_guard <= cur_guard;
    end
    wrong_pwd_revokes_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rf_go && rf_cmd_i == SPA_CMD_PRESENT && !pwd_match |=> granted == 4'h0)
        else $error("mismatch did not revoke rights");
    good_pwd_grants_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rf_go && rf_cmd_i == SPA_CMD_PRESENT && pwd_match |=> granted[$past(rf_slot_i)])
        else $error("match did not grant");
    locked_err_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rf_go && rf_cmd_i == SPA_CMD_LOCK && cur_guard[0] && !(wired_go && wired_wr_i)
        |=> rf_answer_o == ANS_ERR_LOCKED && sector_guard_byte[prev_rf_sector] == prev_cur_guard)
        else $error("relock not refused");
    lock_sets_bit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rf_go && rf_cmd_i == SPA_CMD_LOCK && !cur_guard[0] && !(wired_go && wired_wr_i)
        |=> sector_guard_byte[$past(rf_sector_i)] == {3'h0, $past(rf_data_i[4:1]), 1'b1})
        else $error("lock byte wrong");
    pwd_write_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rf_go && rf_cmd_i == SPA_CMD_WRITE_PWD && !granted[rf_slot_i] |=>
        $stable(password_slot_one) && $stable(password_slot_two) &&
        $stable(password_slot_three))
        else $error("password written without grant");
    wired_write_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wired_go && wired_wr_i && !wired_pwd_ok_i |=> wired_err_o)
        else $error("wired write not refused");
    read_pwd_table_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        q_guard[0] && q_prot == PROT_READ_PWD |=> !query_write_ok_o)
        else $error("write allowed on read-protected sector");
    no_link_closed_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        q_guard[0] && q_guard[GUARD_LINK_LSB +: 2] == 2'h0 && q_prot != PROT_OPEN
        |=> !query_write_ok_o)
        else $error("unlinked locked sector writable");
    unlocked_open_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !q_guard[0] |=> query_read_ok_o && query_write_ok_o)
        else $error("unlocked sector blocked");
    cover_lock_c: cover property (@(posedge clk_i) rf_go && rf_cmd_i == SPA_CMD_LOCK);
    cover_grant_c: cover property (@(posedge clk_i) rf_go && rf_cmd_i == SPA_CMD_PRESENT
        && pwd_match);
    cover_wired_c: cover property (@(posedge clk_i) wired_go && wired_wr_i && wired_pwd_ok_i);
endmodule

// ===== verif/spa_wired_model.sv
`timescale 1ns/10ps
module spa_wired_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic err_i,
    output logic sel_o,
    output logic rd_o,
    output logic wr_o,
    output logic [5:0] sector_o,
    output logic [7:0] wdata_o
);
    // Guard area is only reached with the select bit at one
    initial begin
        sel_o = 1'h1;
        rd_o = 1'h0;
        wr_o = 1'h0;
        sector_o = 6'h00;
        wdata_o = 8'h00;
    end
    // One guard transfer, entered and left at a falling edge; c low aims at the user area
    task automatic xfer(input logic c, input logic w, input logic [5:0] s,
                        input logic [7:0] d, output logic a, output logic e);
        int k;
        sel_o = c;
        sector_o = s;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(negedge clk_i);
        wr_o = 1'h0;
        rd_o = 1'h0;
        for (k = 0; k < 2 && ack_i !== 1'h1 && err_i !== 1'h1; k++)
            @(negedge clk_i);
        a = ack_i;
        e = err_i;
        // Released lines flip so a stale value cannot pass for a held one
        sector_o = ~s;
        wdata_o = ~d;
        sel_o = 1'h1;
        @(negedge clk_i);
    endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import spa_pkg::*;
    logic clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic rf_cmd_valid_i = 1'h0;
    spa_cmd_t rf_cmd_i = SPA_CMD_PRESENT;
    logic [1:0] rf_slot_i = 2'h0;
    logic [5:0] rf_sector_i = 6'h00;
    logic [31:0] rf_data_i = 32'h0;
    logic [5:0] query_sector_i = 6'h00;
    logic wired_pwd_ok_i = 1'h0;
    logic rf_done_o, query_read_ok_o, query_write_ok_o, wired_ack_o, wired_err_o;
    logic [1:0] rf_answer_o, gs, sl;
    logic [7:0] wired_rdata_o, wdata;
    logic sel, rd, wr;
    logic [5:0] wsec, sec;
    logic [7:0] g [64];
    logic [31:0] pw [4];
    logic [31:0] v;
    int errors = 0;
    int comparisons = 0;
    always #2.5 clk_i = ~clk_i;
    spa_sector_guard dut (.clk_i, .rst_b_i, .rf_cmd_valid_i, .rf_cmd_i, .rf_slot_i,
        .rf_sector_i, .rf_data_i, .rf_done_o, .rf_answer_o, .query_sector_i,
        .query_read_ok_o, .query_write_ok_o, .chip_enable_select_bit_i(sel),
        .wired_pwd_ok_i, .wired_rd_i(rd), .wired_wr_i(wr), .wired_sector_i(wsec),
        .wired_wdata_i(wdata), .wired_rdata_o, .wired_ack_o, .wired_err_o);
    spa_wired_model pm (.clk_i, .ack_i(wired_ack_o), .err_i(wired_err_o), .sel_o(sel),
        .rd_o(rd), .wr_o(wr), .sector_o(wsec), .wdata_o(wdata));
    // Expected read and write rights of a guard byte under a granted slot
    function automatic logic [1:0] acc(input logic [7:0] b, input logic [1:0] s);
        logic p;
        p = (s != 2'h0) && (b[4:3] == s);
        if (!b[0])
            return 2'h3;
        case (b[2:1])
            PROT_WRITE_PWD: return {1'h1, p};
            PROT_OPEN: return 2'h3;
            PROT_ALL_PWD: return {p, p};
            default: return {p, 1'h0};
        endcase
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] s, input string n);
        comparisons++;
        if (e !== s) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Contactless command on slot sl and sector sec, answer checked
    task automatic rf(input spa_cmd_t c, input logic [31:0] d, input logic [1:0] e);
        int k;
        rf_cmd_i = c;
        rf_slot_i = sl;
        rf_sector_i = sec;
        rf_data_i = d;
        rf_cmd_valid_i = 1'h1;
        @(negedge clk_i);
        rf_cmd_valid_i = 1'h0;
        for (k = 0; k < 2 && rf_done_o !== 1'h1; k++)
            @(negedge clk_i);
        chk({1'h1, e}, {rf_done_o, rf_answer_o}, "rf answer");
        rf_data_i = ~d;
        @(negedge clk_i);
    endtask
    // Rights and guard byte of sector sec against the model
    task automatic look;
        logic a, e;
        query_sector_i = sec;
        @(negedge clk_i);
        @(negedge clk_i);
        chk(acc(g[sec], gs), {query_read_ok_o, query_write_ok_o}, "rights");
        pm.xfer(1'h1, 1'h0, sec, 8'h00, a, e);
        chk({1'h1, g[sec]}, {a, wired_rdata_o}, "guard read");
    endtask
    task final_report;
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100us;
        errors++;
        final_report();
    end
    // Few sectors are used so that locks often hit locked bytes
    initial begin
        int i;
        logic a, e, c;
        logic [7:0] b;
        v = $urandom(19739);
        pw = '{default: 32'h0};
        g = '{default: 8'h00};
        gs = 2'h0;
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'h1;
        for (i = 0; i < 64; i++) begin
            sec = i[5:0];
            look();
        end
        for (i = 1; i < 4; i++) begin
            sl = i[1:0];
            rf(SPA_CMD_PRESENT, 32'h0, ANS_OK);
            gs = sl;
        end
        repeat (300) begin
            sec = 6'($urandom % 8);
            sl = 2'($urandom);
            v = $urandom;
            b = 8'($urandom % 32);
            case ($urandom % 4)
                0: begin
                    v = v[0] ? pw[sl] : pw[sl] ^ (32'h1 << v[8:4]);
                    e = (sl != 2'h0) && (v === pw[sl]);
                    rf(SPA_CMD_PRESENT, v, e ? ANS_OK : ANS_ERR_MISMATCH);
                    gs = e ? sl : 2'h0;
                end
                1: begin
                    rf(SPA_CMD_LOCK, v, g[sec][0] ? ANS_ERR_LOCKED : ANS_OK);
                    if (!g[sec][0])
                        g[sec] = {3'h0, v[4:1], 1'h1};
                end
                2: begin
                    wired_pwd_ok_i = v[0];
                    c = v[1] | v[2];
                    pm.xfer(c, 1'h1, sec, b, a, e);
                    chk(c, a, "wired ack");
                    chk(c && !v[0], e, "wired refusal");
                    if (c && v[0])
                        g[sec] = b;
                end
                default: begin
                    sl = (sl == 2'h0) ? SLOT_ONE : sl;
                    rf(SPA_CMD_WRITE_PWD, v, gs == sl ? ANS_OK : ANS_ERR_DENIED);
                    if (gs == sl)
                        pw[sl] = v;
                end
            endcase
            look();
        end
        final_report();
    end
endmodule
